// ===== pkg/eqcfg_pkg.sv
// Package of addresses, field layouts, reset values and carrier types for the equalizer output register bank.
package eqcfg_pkg;

  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] HDR_BITS = 5'h08;

  localparam logic [6:0] ADDR_DRV = 7'h01;
  localparam logic [6:0] ADDR_LAUNCH = 7'h02;
  localparam logic [6:0] ADDR_MUTE = 7'h03;
  localparam logic [6:0] ADDR_ID = 7'h04;
  localparam logic [6:0] ADDR_RATE = 7'h05;
  localparam logic [6:0] ADDR_CLEN = 7'h06;
  localparam logic [6:0] ADDR_LREAD = 7'h07;

  localparam int SWING_LSB = 6;
  localparam int CM_LSB = 4;
  localparam int DEEN_BIT = 3;
  localparam int DELVL_LSB = 1;
  localparam int LAUNCH_OPT_BIT = 7;
  localparam int MUTE_SRC_BIT = 5;
  localparam int RATE_BIT = 5;
  localparam int LREAD_LSB = 2;

  localparam logic [1:0] SWING_RST = 2'h2;
  localparam logic [1:0] CM_RST = 2'h2;
  localparam logic DEEN_RST = 1'h0;
  localparam logic [1:0] DELVL_RST = 2'h1;
  localparam logic LAUNCH_OPT_RST = 1'h0;
  localparam logic [6:0] LAUNCH_RSV_RST = 7'h68;
  localparam logic MUTE_SRC_RST = 1'h0;
  localparam logic [4:0] MUTE_THR_RST = 5'h1f;
  localparam logic [1:0] MUTE_RSV_VAL = 2'h0;

  localparam int CLK_PERIOD_NS = 10;
  localparam int SCLK_HALF_MIN_NS = 40;
  localparam int SCLK_HALF_MIN_CYC = (SCLK_HALF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic [1:0] swing;
    logic [1:0] cm;
    logic de_en;
    logic [1:0] de_lvl;
  } eqcfg_drv_t;

  typedef struct packed {
    logic src;
    logic [4:0] thr;
  } eqcfg_mute_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] data;
  } eqcfg_req_t;

endpackage : eqcfg_pkg

// ===== src/eqcfg_sclk_edge.sv
// Edge detector for the serial clock pin, sampled in the system clock domain.
`timescale 1ns/100ps
module eqcfg_sclk_edge (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Serial clock pin.
  input wire logic sclk,
  // Edge pulses.
  output logic rise,
  output logic fall
);
  import eqcfg_pkg::*;

  logic sclk_reg;
  logic sclk_next;

  always_comb begin
    sclk_next = sclk;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_reg <= 1'b0;
    end else begin
      sclk_reg <= sclk_next;
    end
  end

  assign rise = sclk & ~sclk_reg;
  assign fall = ~sclk & sclk_reg;

endmodule : eqcfg_sclk_edge

// ===== src/eqcfg_spi_port.sv
// Serial frame engine: collects a header and data byte, issues register requests and shifts read data out.
`timescale 1ns/100ps
module eqcfg_spi_port (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Serial pins and clock edges.
  input wire logic cs_b,
  input wire logic mosi,
  input wire logic sclk_rise,
  input wire logic sclk_fall,
  output logic miso,
  output logic miso_oe,
  // Register side.
  output eqcfg_pkg::eqcfg_req_t req,
  input wire logic rd_ack,
  input wire logic [7:0] rd_data
);
  import eqcfg_pkg::*;

  logic [4:0] cnt_reg, cnt_next;
  logic [15:0] sh_reg, sh_next;
  logic [7:0] tx_reg, tx_next;
  logic miso_reg, miso_next;
  logic oe_reg, oe_next;
  eqcfg_req_t req_reg, req_next;

  always_comb begin
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    tx_next = tx_reg;
    miso_next = miso_reg;
    oe_next = oe_reg;
    req_next = req_reg;
    req_next.wr = 1'b0;
    req_next.rd = 1'b0;
    if (cs_b) begin
      cnt_next = 5'h00;
      oe_next = 1'b0;
      miso_next = 1'b0;
    end else begin
      oe_next = 1'b1;
      if (sclk_rise && cnt_reg < FRAME_BITS) begin
        sh_next = {sh_reg[14:0], mosi};
        cnt_next = cnt_reg + 5'h01;
        // The read is fetched for every frame so the data byte is ready before the first falling edge.
        if (cnt_reg == HDR_BITS - 5'h01) begin
          req_next.rd = 1'b1;
          req_next.addr = {sh_reg[5:0], mosi};
        end
        if (cnt_reg == FRAME_BITS - 5'h01) begin
          req_next.wr = ~sh_reg[14];
          req_next.addr = sh_reg[13:7];
          req_next.data = {sh_reg[6:0], mosi};
        end
      end
      if (rd_ack) begin
        tx_next = rd_data;
      end
      if (sclk_fall && cnt_reg >= HDR_BITS && cnt_reg < FRAME_BITS) begin
        miso_next = tx_reg[7];
        tx_next = {tx_reg[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 5'h00;
      sh_reg <= 16'h0000;
      tx_reg <= 8'h00;
      miso_reg <= 1'b0;
      oe_reg <= 1'b0;
      req_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      tx_reg <= tx_next;
      miso_reg <= miso_next;
      oe_reg <= oe_next;
      req_reg <= req_next;
    end
  end

  assign miso = miso_reg;
  assign miso_oe = oe_reg;
  assign req = req_reg;

endmodule : eqcfg_spi_port

// ===== src/eqcfg_output_regs.sv
// Output driver, launch amplitude and mute threshold register bank of the cable equalizer.
// Overview of operation
// - Swing field bits 7:6 picks 400/600/700/800 mV; resets to code 10.
// - Common-mode field bits 5:4 picks 0.8/1.0/1.2 V or supply; resets 10.
// - Bit 3 enables de-emphasis when set; resets to zero.
// - De-emphasis level bits 2:1 picks 0/-3/-5/-7 dB; resets to 01.
// - Launch bit 7 resets to 0 for 800 mV; set optimises for 400 mV.
// - Launch bits 6:0 reset to 1101000; host always writes that pattern.
// - Mute threshold bits 7:6 are reserved, read 00; host writes 00.
// - Five-bit mute threshold steps 10 m per code, 00000 at 10 m.
`timescale 1ns/100ps
module eqcfg_output_regs #(
  // Identification byte; the default value is arbitrary.
  parameter logic [7:0] ID_VALUE = 8'h2a
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Serial port pins.
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  // Status from the equalizer core.
  input wire logic rate_is_hd,
  input wire logic [7:0] cable_length_code,
  input wire logic [5:0] launch_amp_level,
  // Configuration to the equalizer core.
  output eqcfg_pkg::eqcfg_drv_t drv_cfg,
  output logic launch_atten_opt,
  output logic [6:0] launch_trim,
  output eqcfg_pkg::eqcfg_mute_t mute_cfg
);
  import eqcfg_pkg::*;

  logic sclk_rise;
  logic sclk_fall;
  eqcfg_req_t req;

  eqcfg_drv_t drv_reg, drv_next;
  logic [7:0] launch_reg, launch_next;
  eqcfg_mute_t mute_reg, mute_next;
  logic [7:0] rd_data_reg, rd_data_next;
  logic rd_ack_reg, rd_ack_next;

  eqcfg_sclk_edge u_edge (
    .clk(clk),
    .rst_b(rst_b),
    .sclk(sclk),
    .rise(sclk_rise),
    .fall(sclk_fall)
  );

  // The host side of the port is the only path into the bank.
  eqcfg_spi_port u_port (
    .clk(clk),
    .rst_b(rst_b),
    .cs_b(cs_b),
    .mosi(mosi),
    .sclk_rise(sclk_rise),
    .sclk_fall(sclk_fall),
    .miso(miso),
    .miso_oe(miso_oe),
    .req(req),
    .rd_ack(rd_ack_reg),
    .rd_data(rd_data_reg)
  );

  function automatic logic [7:0] drv_word(input eqcfg_drv_t d);
    logic [7:0] w;
    w = 8'h00;
    w[SWING_LSB +: 2] = d.swing;
    w[CM_LSB +: 2] = d.cm;
    w[DEEN_BIT] = d.de_en;
    w[DELVL_LSB +: 2] = d.de_lvl;
    return w;
  endfunction : drv_word

  // Write decode: driver and mute take only their writable fields, launch takes all eight bits including reserved 6:0; read-only addresses stay put.
  always_comb begin
    drv_next = drv_reg;
    launch_next = launch_reg;
    mute_next = mute_reg;
    if (req.wr) begin
      case (req.addr)
        ADDR_DRV: begin
          drv_next.swing = req.data[SWING_LSB +: 2];
          drv_next.cm = req.data[CM_LSB +: 2];
          drv_next.de_en = req.data[DEEN_BIT];
          drv_next.de_lvl = req.data[DELVL_LSB +: 2];
        end
        ADDR_LAUNCH: begin
          // The low bits are stored as written; the core relies on the host keeping the pattern.
          launch_next = req.data;
        end
        ADDR_MUTE: begin
          mute_next.src = req.data[MUTE_SRC_BIT];
          mute_next.thr = req.data[4:0];
        end
        default: begin
          drv_next = drv_reg;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      drv_reg <= '{swing: SWING_RST, cm: CM_RST, de_en: DEEN_RST, de_lvl: DELVL_RST};
      launch_reg <= {LAUNCH_OPT_RST, LAUNCH_RSV_RST};
      mute_reg <= '{src: MUTE_SRC_RST, thr: MUTE_THR_RST};
    end else begin
      drv_reg <= drv_next;
      launch_reg <= launch_next;
      mute_reg <= mute_next;
    end
  end

  // Read mux: status registers show the live core inputs at the moment the header completes.
  always_comb begin
    rd_ack_next = req.rd;
    rd_data_next = rd_data_reg;
    if (req.rd) begin
      case (req.addr)
        ADDR_DRV: rd_data_next = drv_word(drv_reg);
        ADDR_LAUNCH: rd_data_next = launch_reg;
        ADDR_MUTE: rd_data_next = {MUTE_RSV_VAL, mute_reg.src, mute_reg.thr};
        ADDR_ID: rd_data_next = ID_VALUE;
        ADDR_RATE: rd_data_next = {2'h0, rate_is_hd, 5'h00};
        ADDR_CLEN: rd_data_next = cable_length_code;
        ADDR_LREAD: rd_data_next = {launch_amp_level, 2'h0};
        default: rd_data_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_reg <= 8'h00;
      rd_ack_reg <= 1'b0;
    end else begin
      rd_data_reg <= rd_data_next;
      rd_ack_reg <= rd_ack_next;
    end
  end

  assign drv_cfg = drv_reg;
  assign launch_atten_opt = launch_reg[LAUNCH_OPT_BIT];
  assign launch_trim = launch_reg[6:0];
  assign mute_cfg = mute_reg;

  // Checks on the bank.
  property p_drv_reset;
    @(posedge clk) $rose(rst_b) |-> drv_cfg.swing == 2'h2 && drv_cfg.cm == 2'h2 && drv_cfg.de_lvl == 2'h1;
  endproperty
  a_drv_reset: assert property (p_drv_reset) else $error("Driver fields left reset wrong.");

  property p_swing_write;
    @(posedge clk) disable iff (!rst_b)
      req.wr && req.addr == ADDR_DRV |=> drv_cfg.swing == $past(req.data[7:6]);
  endproperty
  a_swing_write: assert property (p_swing_write) else $error("Swing field did not take the write.");

  property p_cm_write;
    @(posedge clk) disable iff (!rst_b)
      req.wr && req.addr == ADDR_DRV |=> drv_cfg.cm == $past(req.data[5:4]);
  endproperty
  a_cm_write: assert property (p_cm_write) else $error("Common-mode field did not take the write.");

  property p_deen_write;
    @(posedge clk) disable iff (!rst_b)
      req.wr && req.addr == ADDR_DRV |=> drv_cfg.de_en == $past(req.data[3]);
  endproperty
  a_deen_write: assert property (p_deen_write) else $error("De-emphasis enable did not take the write.");

  property p_deen_reset;
    @(posedge clk) $rose(rst_b) |-> !drv_cfg.de_en ##1 (drv_cfg.de_en == $past(req.wr && req.addr == ADDR_DRV
      && req.data[3]) || !drv_cfg.de_en);
  endproperty
  a_deen_reset: assert property (p_deen_reset) else $error("De-emphasis enable not clear after reset.");

  property p_delvl_write;
    @(posedge clk) disable iff (!rst_b)
      req.wr && req.addr == ADDR_DRV |=> drv_cfg.de_lvl == $past(req.data[2:1]);
  endproperty
  a_delvl_write: assert property (p_delvl_write) else $error("De-emphasis level did not take the write.");

  property p_launch_reset;
    @(posedge clk) $rose(rst_b) |-> !launch_atten_opt && launch_trim == 7'h68;
  endproperty
  a_launch_reset: assert property (p_launch_reset) else $error("Launch register left reset wrong.");

  property p_launch_write;
    @(posedge clk) disable iff (!rst_b)
      req.wr && req.addr == ADDR_LAUNCH |=> launch_atten_opt == $past(req.data[7])
        && launch_trim == $past(req.data[6:0]);
  endproperty
  a_launch_write: assert property (p_launch_write) else $error("Launch register did not take the write.");

  property p_mute_rsv_read;
    @(posedge clk) disable iff (!rst_b)
      req.rd && req.addr == ADDR_MUTE |=> rd_data_reg[7:6] == 2'h0 && rd_data_reg[4:0] == mute_cfg.thr;
  endproperty
  a_mute_rsv_read: assert property (p_mute_rsv_read) else $error("Mute reserved bits read nonzero.");

  property p_mute_write;
    @(posedge clk) disable iff (!rst_b)
      req.wr && req.addr == ADDR_MUTE |=> mute_cfg.thr == $past(req.data[4:0])
        && mute_cfg.src == $past(req.data[5]);
  endproperty
  a_mute_write: assert property (p_mute_write) else $error("Mute threshold did not take the write.");

  property p_mute_reset;
    @(posedge clk) $rose(rst_b) |-> mute_cfg.thr == 5'h1f && !mute_cfg.src;
  endproperty
  a_mute_reset: assert property (p_mute_reset) else $error("Mute threshold left reset wrong.");

  property p_ro_write_ignored;
    @(posedge clk) disable iff (!rst_b)
      req.wr && (req.addr < ADDR_DRV || req.addr > ADDR_MUTE) |=> $stable(drv_cfg) && $stable(launch_trim)
        && $stable(launch_atten_opt) && $stable(mute_cfg);
  endproperty
  a_ro_write_ignored: assert property (p_ro_write_ignored) else $error("Write to read-only address changed state.");

  property p_drv_bit0_read;
    @(posedge clk) disable iff (!rst_b)
      req.rd && req.addr == ADDR_DRV |=> rd_data_reg[0] == 1'b0 && rd_data_reg[7:6] == drv_cfg.swing;
  endproperty
  a_drv_bit0_read: assert property (p_drv_bit0_read) else $error("Driver register read back wrong.");

  property p_clen_read;
    @(posedge clk) disable iff (!rst_b)
      req.rd && req.addr == ADDR_CLEN |=> rd_ack_reg && rd_data_reg == $past(cable_length_code);
  endproperty
  a_clen_read: assert property (p_clen_read) else $error("Cable length read did not show the input.");

  property p_ack_ahead_of_shift;
    @(posedge clk) disable iff (!rst_b)
      req.rd |-> !sclk_fall ##1 (rd_ack_reg && !sclk_fall);
  endproperty
  a_ack_ahead_of_shift: assert property (p_ack_ahead_of_shift) else $error("Read data late for first falling edge.");

  property p_oe_in_frame;
    @(posedge clk) disable iff (!rst_b)
      !cs_b |=> miso_oe;
  endproperty
  a_oe_in_frame: assert property (p_oe_in_frame) else $error("Data out not enabled during a frame.");

  property p_idle_pins;
    @(posedge clk) disable iff (!rst_b)
      cs_b |=> !miso_oe && !miso;
  endproperty
  a_idle_pins: assert property (p_idle_pins) else $error("Data out active while deselected.");

  property p_drv_hold;
    @(posedge clk) disable iff (!rst_b)
      !(req.wr && req.addr == ADDR_DRV) |=> $stable(drv_cfg);
  endproperty
  a_drv_hold: assert property (p_drv_hold) else $error("Driver fields changed without a write.");

  property p_launch_hold;
    @(posedge clk) disable iff (!rst_b)
      !(req.wr && req.addr == ADDR_LAUNCH) |=> $stable(launch_atten_opt) && $stable(launch_trim);
  endproperty
  a_launch_hold: assert property (p_launch_hold) else $error("Launch register changed without a write.");

  property p_mute_hold;
    @(posedge clk) disable iff (!rst_b)
      !(req.wr && req.addr == ADDR_MUTE) |=> $stable(mute_cfg);
  endproperty
  a_mute_hold: assert property (p_mute_hold) else $error("Mute threshold changed without a write.");

  property p_launch_read;
    @(posedge clk) disable iff (!rst_b)
      req.rd && req.addr == ADDR_LAUNCH |=> rd_data_reg == {launch_atten_opt, launch_trim};
  endproperty
  a_launch_read: assert property (p_launch_read) else $error("Launch register read back wrong.");

  property p_drv_fields_read;
    @(posedge clk) disable iff (!rst_b)
      req.rd && req.addr == ADDR_DRV |=> rd_data_reg[5:1] == {drv_cfg.cm, drv_cfg.de_en, drv_cfg.de_lvl};
  endproperty
  a_drv_fields_read: assert property (p_drv_fields_read) else $error("Driver low fields read back wrong.");

  property p_id_read;
    @(posedge clk) disable iff (!rst_b)
      req.rd && req.addr == ADDR_ID |=> rd_data_reg == ID_VALUE;
  endproperty
  a_id_read: assert property (p_id_read) else $error("Identification read back wrong.");

  property p_rate_read;
    @(posedge clk) disable iff (!rst_b)
      req.rd && req.addr == ADDR_RATE |=> rd_data_reg == {2'h0, $past(rate_is_hd), 5'h00};
  endproperty
  a_rate_read: assert property (p_rate_read) else $error("Rate read did not show the input.");

  property p_lread_read;
    @(posedge clk) disable iff (!rst_b)
      req.rd && req.addr == ADDR_LREAD |=> rd_data_reg == {$past(launch_amp_level), 2'h0};
  endproperty
  a_lread_read: assert property (p_lread_read) else $error("Launch level read did not show the input.");

  property p_unmapped_read;
    @(posedge clk) disable iff (!rst_b)
      req.rd && (req.addr == 7'h00 || req.addr > ADDR_LREAD) |=> rd_data_reg == 8'h00;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("Unmapped address read nonzero.");

endmodule : eqcfg_output_regs

// ===== dv/eqcfg_host_model.sv
// Serial host model that frames register reads and writes towards the equalizer register bank.
`timescale 1ns/100ps
module eqcfg_host_model (
  // Clock.
  input wire logic clk,
  // Serial pins.
  output logic sclk,
  output logic cs_b,
  output logic mosi,
  input wire logic miso
);
  import eqcfg_pkg::*;

  initial begin
    sclk = 1'h0;
    cs_b = 1'h1;
    mosi = 1'h0;
  end

  // Pins change only at falling edges of clk, well away from the edge that samples them.
  task automatic frame(input logic [15:0] word, input int nbits, output logic [7:0] rdata);
    rdata = 8'h00;
    @(negedge clk);
    cs_b = 1'h0;
    for (int i = 15; i > 15 - nbits; i--) begin
      mosi = word[i];
      repeat (SCLK_HALF_MIN_CYC) @(negedge clk);
      if (i < 8) rdata = {rdata[6:0], miso};
      sclk = 1'h1;
      repeat (SCLK_HALF_MIN_CYC) @(negedge clk);
      sclk = 1'h0;
    end
    repeat (SCLK_HALF_MIN_CYC) @(negedge clk);
    cs_b = 1'h1;
    // A deselected data line keeps no meaningful value, so it is flipped rather than held.
    mosi = ~mosi;
    repeat (4) @(negedge clk);
  endtask : frame

  task automatic write_reg(input logic [6:0] addr, input logic [7:0] data);
    logic [7:0] unused;
    if (addr == ADDR_LAUNCH) data[6:0] = LAUNCH_RSV_RST;
    if (addr == ADDR_MUTE) data[7:6] = MUTE_RSV_VAL;
    frame({1'h0, addr, data}, 16, unused);
  endtask : write_reg

  task automatic read_reg(input logic [6:0] addr, output logic [7:0] data);
    frame({1'h1, addr, 8'h00}, 16, data);
  endtask : read_reg
endmodule : eqcfg_host_model

// ===== dv/eqcfg_output_regs_tb_top.sv
// Self-checking testbench of the equalizer output register bank.
`timescale 1ns/100ps
module eqcfg_output_regs_tb_top;
  import eqcfg_pkg::*;

  // Identification value is arbitrary.
  localparam logic [7:0] ID_TB = 8'h5c;

  logic clk;
  logic rst_b;
  logic sclk;
  logic cs_b;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic rate_is_hd;
  logic [7:0] cable_length_code;
  logic [5:0] launch_amp_level;
  eqcfg_drv_t drv_cfg;
  logic launch_atten_opt;
  logic [6:0] launch_trim;
  eqcfg_mute_t mute_cfg;
  int failures = 0;
  int n_tests = 0;
  int seed = 95380;
  logic [7:0] sh_drv = 8'ha2;
  logic [7:0] sh_launch = 8'h68;
  logic [7:0] sh_mute = 8'h1f;
  logic [7:0] d;

  eqcfg_output_regs #(.ID_VALUE(ID_TB)) eqcfg_output_regs_i (
    .clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
    .rate_is_hd(rate_is_hd), .cable_length_code(cable_length_code), .launch_amp_level(launch_amp_level),
    .drv_cfg(drv_cfg), .launch_atten_opt(launch_atten_opt), .launch_trim(launch_trim), .mute_cfg(mute_cfg)
  );

  eqcfg_host_model eqcfg_host_model_i (.clk(clk), .sclk(sclk), .cs_b(cs_b), .mosi(mosi), .miso(miso));

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  function automatic logic [7:0] exp_rd(input logic [6:0] a);
    case (a)
      ADDR_DRV: return {sh_drv[7:1], 1'h0};
      ADDR_LAUNCH: return sh_launch;
      ADDR_MUTE: return sh_mute;
      ADDR_ID: return ID_TB;
      ADDR_RATE: return {2'h0, rate_is_hd, 5'h00};
      ADDR_CLEN: return cable_length_code;
      ADDR_LREAD: return {launch_amp_level, 2'h0};
      default: return 8'h00;
    endcase
  endfunction : exp_rd

  // Writes through the host and updates the expected register image the same way the bank should.
  task automatic wr(input logic [6:0] a, input logic [7:0] data);
    eqcfg_host_model_i.write_reg(a, data);
    if (a == ADDR_DRV) sh_drv = data;
    if (a == ADDR_LAUNCH) sh_launch = {data[7], 7'h68};
    if (a == ADDR_MUTE) sh_mute = {2'h0, data[5:0]};
  endtask : wr

  task automatic compare_all();
    logic [7:0] rd;
    rate_is_hd = 1'($random(seed));
    cable_length_code = 8'($random(seed));
    launch_amp_level = 6'($random(seed));
    check("drv_cfg", {1'h0, drv_cfg}, {1'h0, sh_drv[7:1]});
    check("launch", {launch_atten_opt, launch_trim}, sh_launch);
    check("mute_cfg", {2'h0, mute_cfg}, sh_mute);
    check("idle_pins", {6'h00, miso_oe, miso}, 8'h00);
    for (int a = 0; a < 9; a++) begin
      eqcfg_host_model_i.read_reg((a == 8) ? 7'h55 : 7'(a), rd);
      check("readback", rd, exp_rd((a == 8) ? 7'h55 : 7'(a)));
    end
  endtask : compare_all

  initial begin
    logic [7:0] rd;
    logic [6:0] ro_addr [6];
    logic [4:0] thr_tab [4];
    ro_addr = '{7'h00, ADDR_ID, ADDR_RATE, ADDR_CLEN, ADDR_LREAD, 7'h7f};
    thr_tab = '{5'h00, 5'h0f, 5'h10, 5'h1f};
    rst_b = 1'h0;
    rate_is_hd = 1'h0;
    cable_length_code = 8'h00;
    launch_amp_level = 6'h00;
    repeat (12) @(negedge clk);
    rst_b = 1'h1;
    repeat (2) @(negedge clk);
    compare_all();
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      d = (i < 4) ? {2'(i), 2'(i), 1'(i), 2'(i), 1'h1} : 8'($random(seed));
      wr(ADDR_DRV, d);
      compare_all();
    end
    $display("test output driver done");
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_LAUNCH, {1'(i), 7'($random(seed))});
      compare_all();
    end
    $display("test launch amplitude done");
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_MUTE, {2'($random(seed)), 1'(i), thr_tab[i]});
      compare_all();
    end
    $display("test mute threshold done");
    // Read-only and unmapped places must ignore writes and leave every setting alone.
    for (int i = 0; i < 6; i++) begin
      wr(ro_addr[i], 8'($random(seed)));
      compare_all();
    end
    $display("test read-only writes done");
    // A frame cut short after twelve bits must not write anything.
    eqcfg_host_model_i.frame({1'h0, ADDR_DRV, 8'h00}, 12, rd);
    compare_all();
    $display("test aborted frame done");
    tally_and_finish();
  end

  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
endmodule : eqcfg_output_regs_tb_top
